// File: verilog/beacon_reply_cfg.svh
// timing counts, widths and field constants for the reply decoder
`ifndef BEACON_REPLY_CFG_SVH
`define BEACON_REPLY_CFG_SVH

// ----------------------------------------------------------------
// clocks and derived tick rates
// ----------------------------------------------------------------
`define CLK_KHZ 100000
`define PROC_KHZ 8276
`define RANGE_KHZ 16552

// ----------------------------------------------------------------
// reply timing
// ----------------------------------------------------------------
`define FRAME_NS 20300
`define FRAME_TICKS ((`FRAME_NS * `PROC_KHZ) / 1000000)
`define CODE_NS 1450
`define CODE_TICKS ((`CODE_NS * `PROC_KHZ) / 1000000)
`define CLOSE_POS 4'hE
`define X_POS 4'h7

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define NCODE 12
`define AZ_W 10
`define BORE_W 12
`define RNG_W 16
`define ACC_W 18
`define ATTR_W 2

`endif

// File: verilog/beacon_reply_pkg.sv
// types shared by the reply decoder
`include "beacon_reply_cfg.svh"
package beacon_reply_pkg;

  typedef enum logic [1:0] {
    MODE_A = 2'b00,
    MODE_C = 2'b01,
    MODE_2 = 2'b10
  } mode_t;

  typedef struct packed {
    logic [`RNG_W-1:0] rng;
    logic [`BORE_W-1:0] bore;
    logic [`AZ_W-1:0] ref_az;
    logic [`NCODE-1:0] code;
    logic [`NCODE-1:0] conf;
    logic [`ATTR_W-1:0] attr;
  } reply_t;

endpackage

// File: verilog/beacon_reply_detect_decode.sv
// framing detection, code decoding and reporting for beacon replies
//
// Overview of operation
// - two pulses one framing interval apart declare a candidate reply
// - candidate kept only if the leading pulse is mainbeam and ungarbled, or the closing pulse is mainbeam
// - each pulse carries its sidelobe marking along the delay line
// - candidate opened on another reply's code position is dropped as phantom when its closing pulse opens a new reply
// - every one of twelve code positions is decided for each reply
// - each code bit has a confidence flag, low when ambiguous
// - empty position gives sure zero
// - mainbeam pulse matching only own reference gives sure one
// - sidelobe pulse, or match only to another reply, gives doubtful zero
// - match to nothing, or to own and another, gives doubtful one
// - reference from first framing pulse, second when first is garbled
// - each sure one averages the reference with the new sample
// - once per sweep report mode and antenna boresight azimuth
// - per reply report range, azimuth, reference, code, confidence, attributes
// - range counts from interrogation to first framing pulse arrival
// - reply boresight is antenna azimuth when the reply was received
// - reply azimuth estimate built from its reference pulse and its sure-one samples
// - four decoder slots handle overlapping replies
// - processing at 8.276 MHz, range counted at 16.552 MHz
`timescale 1ns/1ps
`include "beacon_reply_cfg.svh"
module beacon_reply_detect_decode #(
  parameter int NSLOT = 4
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_range_gate, // listening interval
  input wire beacon_reply_pkg::mode_t i_sweep_mode, // sweep mode
  input wire logic [`BORE_W-1:0] i_antenna_az, // antenna azimuth
  input wire logic i_pulse_valid, // leading edge on a processing tick
  input wire logic i_pulse_sidelobe, // sidelobe marking of the pulse
  input wire logic [`AZ_W-1:0] i_pulse_az, // monopulse sample
  input wire logic [`AZ_W-1:0] i_az_tol, // match tolerance
  input wire logic i_reply_ready, // collector accepts reply
  output logic o_reply_valid, // reply word present
  output logic [`RNG_W-1:0] o_reply_range, // range ticks
  output logic [`BORE_W-1:0] o_reply_bore_az, // boresight azimuth
  output logic [`AZ_W-1:0] o_reply_ref_az, // monopulse reference
  output logic [`NCODE-1:0] o_reply_code, // code bits
  output logic [`NCODE-1:0] o_reply_conf, // confidence bits
  output logic [`ATTR_W-1:0] o_reply_attr, // {phantom suspect, leading pulse garbled}
  output logic o_sweep_valid, // sweep header pulse
  output beacon_reply_pkg::mode_t o_sweep_mode, // sweep mode
  output logic [`BORE_W-1:0] o_sweep_bore_az, // sweep boresight
  output logic o_proc_tick // processing-rate enable
);
  import beacon_reply_pkg::*;

  localparam int IW = (NSLOT > 1) ? $clog2(NSLOT) : 1;
  localparam int DW = `AZ_W + 2;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [IW:0] first_set(input logic [NSLOT-1:0] v);
    logic [IW:0] r;
    r = '0;
    for (int i = NSLOT - 1; i >= 0; i--)
    begin
      if (v[i])
        r = {1'b1, IW'(i)};
    end
    return r;
  endfunction

  function automatic logic corr(input logic [`AZ_W-1:0] a, input logic [`AZ_W-1:0] b,
                                input logic [`AZ_W-1:0] tol);
    logic [`AZ_W-1:0] d;
    d = (a > b) ? a - b : b - a;
    return d <= tol;
  endfunction

  function automatic logic [`AZ_W-1:0] avg(input logic [`AZ_W-1:0] a,
                                           input logic [`AZ_W-1:0] b);
    logic [`AZ_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[`AZ_W:1];
  endfunction

  // {bit, confidence}
  function automatic logic [1:0] decide(input logic v, input logic sl,
                                        input logic own, input logic oth);
    if (!v)
      return 2'b01;
    else if (sl)
      return 2'b00;
    else if (own && !oth)
      return 2'b11;
    else if (!own && oth)
      return 2'b00;
    else
      return 2'b10;
  endfunction

  function automatic logic is_code(input logic [3:0] p);
    return (p >= 4'h1) && (p < `CLOSE_POS) && (p != `X_POS);
  endfunction

  function automatic logic [3:0] code_idx(input logic [3:0] p);
    return (p < `X_POS) ? p - 4'h1 : p - 4'h2;
  endfunction

  // ----------------------------------------------------------------
  // tick dividers
  // ----------------------------------------------------------------
  logic [`ACC_W-1:0] acc_r;
  logic [`ACC_W-1:0] acc_sum;
  logic r_tick_r;
  logic half_r;
  logic p_tick;
  // fractional divider: average rate exact, jitter of one system cycle
  assign acc_sum = acc_r + `ACC_W'(`RANGE_KHZ);
  assign p_tick = r_tick_r & half_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      acc_r <= '0;
      r_tick_r <= 1'b0;
      half_r <= 1'b0;
    end
    else
    begin
      r_tick_r <= (acc_sum >= `ACC_W'(`CLK_KHZ));
      acc_r <= (acc_sum >= `ACC_W'(`CLK_KHZ)) ? acc_sum - `ACC_W'(`CLK_KHZ) : acc_sum;
      if (r_tick_r)
        half_r <= ~half_r;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_proc_tick <= 1'b0;
    else
      o_proc_tick <= p_tick;
  end

  // ----------------------------------------------------------------
  // range gate, range counter, sweep header
  // ----------------------------------------------------------------
  logic gate_d_r;
  logic gate_rise;
  logic [`RNG_W-1:0] rng_r;
  assign gate_rise = i_range_gate & ~gate_d_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      gate_d_r <= 1'b0;
      rng_r <= '0;
    end
    else
    begin
      gate_d_r <= i_range_gate;
      if (gate_rise)
        rng_r <= '0;
      else if (i_range_gate && r_tick_r)
        rng_r <= rng_r + `RNG_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_sweep_valid <= 1'b0;
      o_sweep_mode <= MODE_A;
      o_sweep_bore_az <= '0;
    end
    else
    begin
      o_sweep_valid <= gate_rise;
      if (gate_rise)
      begin
        o_sweep_mode <= i_sweep_mode;
        o_sweep_bore_az <= i_antenna_az;
      end
    end
  end

  // ----------------------------------------------------------------
  // framing delay line and candidate detection
  // ----------------------------------------------------------------
  logic [DW-1:0] dly_r [`FRAME_TICKS];
  logic dly_v;
  logic dly_sl;
  logic [`AZ_W-1:0] dly_az;
  assign {dly_v, dly_sl, dly_az} = dly_r[`FRAME_TICKS-1];

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < `FRAME_TICKS; i++)
        dly_r[i] <= '0;
    end
    else if (p_tick)
    begin
      dly_r[0] <= {i_pulse_valid & i_range_gate, i_pulse_sidelobe, i_pulse_az};
      for (int i = 1; i < `FRAME_TICKS; i++)
        dly_r[i] <= dly_r[i-1];
    end
  end

  logic [NSLOT-1:0] busy_v;
  logic [NSLOT-1:0] done_v;
  logic [NSLOT-1:0] corr_v;
  logic [NSLOT-1:0] susp_v;
  logic [IW:0] free_sel;
  logic [IW:0] done_sel;
  logic lead_garb;
  logic frame_ok;
  logic cand_ok;
  logic alloc;
  logic take;
  logic in_ready;

  assign lead_garb = |(busy_v & ~done_v);
  // leading pulse is the delayed one, closing pulse the live one
  assign frame_ok = (~dly_sl & ~lead_garb) | ~i_pulse_sidelobe;
  assign cand_ok = p_tick & i_range_gate & dly_v & i_pulse_valid & frame_ok;
  assign free_sel = first_set(~busy_v);
  assign alloc = cand_ok & free_sel[IW];
  assign done_sel = first_set(done_v);
  assign take = done_sel[IW] & in_ready;

  // ----------------------------------------------------------------
  // decoder slots
  // ----------------------------------------------------------------
  reply_t rec_r [NSLOT];
  logic busy_r [NSLOT];
  logic done_r [NSLOT];
  logic [3:0] pos_r [NSLOT];
  logic [3:0] sub_r [NSLOT];
  logic [1:0] dec_v [NSLOT];

  genvar g;
  generate
    for (g = 0; g < NSLOT; g++)
    begin : g_slot
      logic oth;
      logic at_close;
      logic at_code;
      assign busy_v[g] = busy_r[g];
      assign done_v[g] = done_r[g];
      assign corr_v[g] = corr(dly_az, rec_r[g].ref_az, i_az_tol);
      assign oth = |(corr_v & busy_v & ~(NSLOT'(1) << g));
      assign dec_v[g] = decide(dly_v, dly_sl, corr_v[g], oth);
      assign at_close = (pos_r[g] == `CLOSE_POS) && (sub_r[g] == 4'h0);
      assign at_code = is_code(pos_r[g]) && (sub_r[g] == 4'h0);
      assign susp_v[g] = busy_r[g] & ~done_r[g] & at_code;

      always_ff @(posedge i_clk_sys or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          busy_r[g] <= 1'b0;
          done_r[g] <= 1'b0;
          pos_r[g] <= '0;
          sub_r[g] <= '0;
          rec_r[g] <= '0;
        end
        else if (gate_rise)
        begin
          busy_r[g] <= 1'b0;
          done_r[g] <= 1'b0;
        end
        else if (alloc && free_sel[IW-1:0] == IW'(g))
        begin
          busy_r[g] <= 1'b1;
          done_r[g] <= 1'b0;
          pos_r[g] <= 4'h0;
          sub_r[g] <= 4'h1;
          rec_r[g].ref_az <= lead_garb ? i_pulse_az : dly_az;
          rec_r[g].rng <= rng_r - `RNG_W'(2 * `FRAME_TICKS);
          rec_r[g].bore <= i_antenna_az;
          rec_r[g].code <= '0;
          rec_r[g].conf <= '0;
          rec_r[g].attr <= {|susp_v, lead_garb};
        end
        else if (take && done_sel[IW-1:0] == IW'(g))
        begin
          busy_r[g] <= 1'b0;
          done_r[g] <= 1'b0;
        end
        else if (p_tick && busy_r[g] && !done_r[g])
        begin
          if (dec_v[g] == 2'b11 && (at_close || at_code))
            rec_r[g].ref_az <= avg(rec_r[g].ref_az, dly_az);
          if (at_close)
          begin
            // a suspect whose closing pulse opens a new reply sits between two replies
            busy_r[g] <= ~(rec_r[g].attr[1] & cand_ok);
            done_r[g] <= ~(rec_r[g].attr[1] & cand_ok);
          end
          else
          begin
            if (at_code)
            begin
              rec_r[g].code[code_idx(pos_r[g])] <= dec_v[g][1];
              rec_r[g].conf[code_idx(pos_r[g])] <= dec_v[g][0];
            end
            if (sub_r[g] == 4'(`CODE_TICKS - 1))
            begin
              sub_r[g] <= 4'h0;
              pos_r[g] <= pos_r[g] + 4'h1;
            end
            else
              sub_r[g] <= sub_r[g] + 4'h1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // two-entry reply buffer
  // ----------------------------------------------------------------
  reply_t out_r;
  reply_t skid_r;
  logic out_v_r;
  logic skid_v_r;
  // finished slots hold until a buffer entry frees, so no reply is lost before the next gate rise clears them
  assign in_ready = ~skid_v_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      out_r <= '0;
      skid_r <= '0;
      out_v_r <= 1'b0;
      skid_v_r <= 1'b0;
    end
    else if (!out_v_r || i_reply_ready)
    begin
      if (skid_v_r)
      begin
        out_r <= skid_r;
        skid_v_r <= 1'b0;
      end
      else
      begin
        out_v_r <= take;
        if (take)
          out_r <= rec_r[done_sel[IW-1:0]];
      end
    end
    else if (take)
    begin
      skid_r <= rec_r[done_sel[IW-1:0]];
      skid_v_r <= 1'b1;
    end
  end

  assign o_reply_valid = out_v_r;
  assign o_reply_range = out_r.rng;
  assign o_reply_bore_az = out_r.bore;
  assign o_reply_ref_az = out_r.ref_az;
  assign o_reply_code = out_r.code;
  assign o_reply_conf = out_r.conf;
  assign o_reply_attr = out_r.attr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sweep_header: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(i_range_gate) |=> o_sweep_valid && o_sweep_mode == $past(i_sweep_mode))
    else $error("sweep header missing after gate rise");

  a_gate_clears: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    gate_rise |=> busy_v == '0 && done_v == '0)
    else $error("slots not cleared by range gate");

  a_range_rate: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    r_tick_r |=> !r_tick_r [*5])
    else $error("range tick faster than its rate");

  a_frame_alloc: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    alloc && !gate_rise |=> busy_v[$past(free_sel[IW-1:0])])
    else $error("candidate not given a slot");

  a_sidelobe_pair: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !(alloc && dly_sl && i_pulse_sidelobe))
    else $error("sidelobe-only candidate accepted");

  a_empty_zero: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !dly_v |-> dec_v[0] == 2'b01)
    else $error("empty position not sure zero");

  a_sidelobe_low: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    dly_v && dly_sl |-> dec_v[0] == 2'b00)
    else $error("sidelobe position not doubtful zero");

  a_ref_average: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    p_tick && busy_r[0] && !done_r[0] && !take && !gate_rise && !alloc
    && g_slot[0].at_code && dec_v[0] == 2'b11
    |=> rec_r[0].ref_az == avg($past(rec_r[0].ref_az), $past(dly_az)))
    else $error("reference not averaged on sure one");

  a_buffer_hold: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_reply_valid && !i_reply_ready |=> o_reply_valid && $stable(o_reply_code))
    else $error("reply dropped under stall");

endmodule

// File: sim/beacon_video_model.sv
// pulse stream source and reply word collector facing the decoder
`timescale 1ns/1ps
`include "beacon_reply_cfg.svh"
module beacon_video_model (
  input wire logic i_clk_sys, // system clock
  input wire logic i_proc_tick, // processing tick seen
  input wire logic i_reply_valid, // reply word present
  input wire beacon_reply_pkg::reply_t i_reply, // reply fields
  output logic o_pulse_valid, // pulse present
  output logic o_pulse_sidelobe, // sidelobe marking
  output logic [`AZ_W-1:0] o_pulse_az, // monopulse sample
  output logic o_reply_ready // collector accepts
);
  import beacon_reply_pkg::*;
  logic [11:0] sched [0:511];
  int tick_n = -1;
  logic run = 1'b0;
  logic hold = 1'b0;
  reply_t words [$];

  initial
  begin
    o_pulse_valid = 1'b0;
    o_pulse_sidelobe = 1'b0;
    o_pulse_az = 10'h155;
    o_reply_ready = 1'b1;
  end

  task automatic clear();
    for (int i = 0; i < 512; i++)
      sched[i] = 12'h000;
    run = 1'b0;
    tick_n = -1;
    words.delete();
  endtask

  task automatic put(input int t, input logic sl, input logic [9:0] az);
    sched[t] = {1'b1, sl, az};
  endtask

  // -----------------------------------------------------------
  // one pulse per processing window, lines scrambled when idle
  // -----------------------------------------------------------
  always @(negedge i_clk_sys)
  begin
    o_reply_ready <= !hold;
    if (run && i_proc_tick)
    begin
      tick_n = tick_n + 1;
      if (tick_n < 512 && sched[tick_n][11])
      begin
        o_pulse_valid <= 1'b1;
        o_pulse_sidelobe <= sched[tick_n][10];
        o_pulse_az <= sched[tick_n][9:0];
      end
      else
      begin
        o_pulse_valid <= 1'b0;
        o_pulse_sidelobe <= ~o_pulse_sidelobe;
        o_pulse_az <= ~o_pulse_az;
      end
    end
  end

  always @(posedge i_clk_sys)
    if (i_reply_valid && o_reply_ready)
      words.push_back(i_reply);
endmodule

// File: sim/tb_beacon_reply_detect_decode.sv
// self-checking bench for the reply detector and decoder
`timescale 1ns/1ps
`include "beacon_reply_cfg.svh"
module tb_beacon_reply_detect_decode;
  import beacon_reply_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_range_gate = 1'b0;
  mode_t i_sweep_mode = MODE_A;
  logic [`BORE_W-1:0] i_antenna_az = 12'h000;
  logic [`AZ_W-1:0] i_az_tol = 10'h008;
  logic pulse_valid, pulse_sidelobe, reply_ready, reply_valid, sweep_valid, proc_tick;
  logic [`AZ_W-1:0] pulse_az, reply_ref_az;
  logic [`RNG_W-1:0] reply_range;
  logic [`BORE_W-1:0] reply_bore_az, sweep_bore_az;
  logic [`NCODE-1:0] reply_code, reply_conf;
  logic [`ATTR_W-1:0] reply_attr;
  mode_t sweep_mode;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 i_clk_sys = ~i_clk_sys;

  beacon_reply_detect_decode beacon_reply_detect_decode_inst (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_range_gate(i_range_gate),
    .i_sweep_mode(i_sweep_mode), .i_antenna_az(i_antenna_az), .i_pulse_valid(pulse_valid),
    .i_pulse_sidelobe(pulse_sidelobe), .i_pulse_az(pulse_az), .i_az_tol(i_az_tol),
    .i_reply_ready(reply_ready), .o_reply_valid(reply_valid), .o_reply_range(reply_range),
    .o_reply_bore_az(reply_bore_az), .o_reply_ref_az(reply_ref_az), .o_reply_code(reply_code),
    .o_reply_conf(reply_conf), .o_reply_attr(reply_attr), .o_sweep_valid(sweep_valid),
    .o_sweep_mode(sweep_mode), .o_sweep_bore_az(sweep_bore_az), .o_proc_tick(proc_tick));

  beacon_video_model beacon_video_model_inst (
    .i_clk_sys(i_clk_sys), .i_proc_tick(proc_tick), .i_reply_valid(reply_valid),
    .i_reply({reply_range, reply_bore_az, reply_ref_az, reply_code, reply_conf, reply_attr}),
    .o_pulse_valid(pulse_valid), .o_pulse_sidelobe(pulse_sidelobe), .o_pulse_az(pulse_az),
    .o_reply_ready(reply_ready));

  // -----------------------------------------------------------
  // shared checks and sequencing
  // -----------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // range ticks jitter by the gate-to-window offset, so a small span
  task automatic chk_rng(input logic [15:0] got, input int lo);
    chk((got >= lo && got <= lo + 8) ? 16'h0001 : 16'h0000, 16'h0001, "range");
  endtask

  task automatic gate_rise(input mode_t m, input logic [11:0] az);
    @(negedge i_clk_sys);
    i_range_gate = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    i_sweep_mode = m;
    i_antenna_az = az;
    i_range_gate = 1'b1;
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk(sweep_valid, 1, "sweep pulse");
    chk(sweep_mode, m, "sweep mode");
    chk(sweep_bore_az, az, "sweep azimuth");
    @(negedge i_clk_sys);
    chk(sweep_valid, 0, "sweep pulse width");
  endtask

  task automatic wait_tick(input int t);
    while (beacon_video_model_inst.tick_n < t)
      @(negedge i_clk_sys);
  endtask

  task automatic wait_words(input int n);
    while (beacon_video_model_inst.words.size() < n && beacon_video_model_inst.tick_n < 700)
      @(negedge i_clk_sys);
    chk(beacon_video_model_inst.words.size(), n, "reply count");
  endtask

  task automatic chk_word(input int i, input logic [11:0] code, input logic [11:0] conf,
                          input logic [9:0] ref_az, input logic [1:0] attr, input int rng);
    reply_t w;
    w = beacon_video_model_inst.words[i];
    chk(w.code, code, "code");
    chk(w.conf, conf, "confidence");
    chk(w.ref_az, ref_az, "reference");
    chk(w.attr, attr, "attributes");
    chk(w.bore, i_antenna_az, "reply azimuth");
    chk_rng(w.rng, rng);
  endtask

  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic t_sweep();
    int n;
    int lo;
    n = 0;
    lo = (`PROC_KHZ * 1000) / `CLK_KHZ;
    gate_rise(MODE_C, 12'hFFF);
    gate_rise(MODE_2, 12'h5A5);
    // window phase allows one tick of slack around the average rate
    repeat (1000)
    begin
      @(negedge i_clk_sys);
      if (proc_tick === 1'b1)
        n++;
    end
    chk((n >= lo && n <= lo + 1) ? 16'h0001 : 16'h0000, 16'h0001, "processing rate");
    $display("test sweep done");
  endtask

  task automatic t_single();
    beacon_video_model_inst.clear();
    beacon_video_model_inst.put(10, 0, 10'h064);
    beacon_video_model_inst.put(22, 0, 10'h068);
    beacon_video_model_inst.put(46, 1, 10'h064);
    beacon_video_model_inst.put(58, 0, 10'h12C);
    beacon_video_model_inst.put(70, 0, 10'h06A);
    beacon_video_model_inst.put(106, 0, 10'h068);
    beacon_video_model_inst.put(178, 0, 10'h068);
    gate_rise(MODE_A, 12'h123);
    beacon_video_model_inst.run = 1'b1;
    wait_words(1);
    // sure ones at 1,5,8; sidelobe at 3; unmatched at 4
    chk_word(0, 12'h059, 12'hFF3, 10'h068, 2'b00, 20);
    $display("test single done");
  endtask

  task automatic t_sidelobe();
    beacon_video_model_inst.clear();
    beacon_video_model_inst.put(10, 1, 10'h0C8);
    beacon_video_model_inst.put(178, 1, 10'h0C8);
    beacon_video_model_inst.put(310, 1, 10'h0C8);
    beacon_video_model_inst.put(478, 0, 10'h0CC);
    gate_rise(MODE_C, 12'h0F0);
    beacon_video_model_inst.run = 1'b1;
    wait_tick(660);
    wait_words(1);
    chk_word(0, 12'h000, 12'hFFF, 10'h0CA, 2'b00, 620);
    $display("test sidelobe done");
  endtask

  task automatic t_overlap();
    reply_t w;
    beacon_video_model_inst.clear();
    beacon_video_model_inst.hold = 1'b1;
    beacon_video_model_inst.put(10, 0, 10'h064);
    beacon_video_model_inst.put(34, 0, 10'h190);
    beacon_video_model_inst.put(82, 0, 10'h064);
    beacon_video_model_inst.put(130, 0, 10'h0FA);
    beacon_video_model_inst.put(178, 0, 10'h064);
    beacon_video_model_inst.put(202, 0, 10'h190);
    gate_rise(MODE_2, 12'h3C3);
    beacon_video_model_inst.run = 1'b1;
    wait_tick(440);
    // both words parked in the buffer while the collector stalls
    chk(reply_valid, 1, "stalled word held");
    chk(beacon_video_model_inst.words.size(), 0, "nothing taken while stalled");
    beacon_video_model_inst.hold = 1'b0;
    wait_words(2);
    w = beacon_video_model_inst.words[0];
    chk(w.code & 12'hFFD, 12'h120, "first reply code");
    chk(w.conf, 12'hEFD, "first reply confidence");
    chk(w.ref_az, 10'h064, "first reference");
    chk(w.attr, 2'b00, "first attributes");
    chk_rng(w.rng, 20);
    chk_word(1, 12'h040, 12'hBB7, 10'h190, 2'b11, 68);
    $display("test overlap done");
  endtask

  task automatic t_phantom();
    beacon_video_model_inst.clear();
    beacon_video_model_inst.put(10, 0, 10'h064);
    beacon_video_model_inst.put(34, 0, 10'h064);
    beacon_video_model_inst.put(178, 0, 10'h064);
    beacon_video_model_inst.put(202, 0, 10'h190);
    beacon_video_model_inst.put(370, 0, 10'h190);
    gate_rise(MODE_A, 12'h321);
    beacon_video_model_inst.run = 1'b1;
    // a surviving middle bracket would have shown up well before this
    wait_tick(560);
    wait_words(2);
    chk_word(0, 12'h002, 12'hFFF, 10'h064, 2'b00, 20);
    chk_word(1, 12'h000, 12'hFFF, 10'h190, 2'b01, 404);
    $display("test phantom done");
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ceiling well above the five scenarios, about 25k cycles
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles > 60000)
    begin
      fails++;
      $display("MISMATCH t=%0t timeout", $time);
      report_and_stop();
    end
  end

  initial
  begin
    beacon_video_model_inst.clear();
    repeat (16) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    chk(reply_valid, 0, "idle after reset");
    t_sweep();
    t_single();
    t_sidelobe();
    t_overlap();
    t_phantom();
    report_and_stop();
  end
endmodule
